// *** design/fault_response.sv ***
// Restart decisions after desync or overcurrent events, coast decisions after desync events
`timescale 1ns/1ps
module fault_response (
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic brakeCommand,
  input wire logic autoRestartSelect,
  input wire logic faultDisplayLatch,
  input wire logic desyncFault,
  input wire logic softOvercurrent,
  input wire logic hardOvercurrent,
  output logic restartPulse,
  output logic coastHold
);

  logic [2:0] prev_reg;
  logic restart_reg;
  logic coast_reg;
  logic coast_next;
  logic [2:0] events;
  logic anyEvent;
  logic restartAllowed;

  assign events = {desyncFault, softOvercurrent, hardOvercurrent} & ~prev_reg;
  assign anyEvent = |events;
  assign restartAllowed = autoRestartSelect & run & ~brakeCommand
      & faultDisplayLatch;
  assign coast_next = !run ? 1'b0
      : (events[2] & ~restartAllowed) ? 1'b1 : coast_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_reg <= 3'h0;
      restart_reg <= 1'b0;
      coast_reg <= 1'b0;
    end else begin
      prev_reg <= {desyncFault, softOvercurrent, hardOvercurrent};
      // Events on adjacent cycles still give a one-cycle request
      restart_reg <= anyEvent & restartAllowed & ~restart_reg;
      coast_reg <= coast_next;
    end
  end

  assign restartPulse = restart_reg;
  assign coastHold = coast_reg;

endmodule // fault_response

// *** design/motor_run_control_register.sv ***
// Run-control register bank of the motor driver, AHB-Lite slave
`timescale 1ns/1ps
`include "motor_run_defines.svh"
module motor_run_control_register
  import motor_run_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic directionPin,
  input wire logic hardwareResetPinN,
  input wire logic desyncFault,
  input wire logic softOvercurrentProtection,
  input wire logic hardOvercurrentProtection,
  input wire logic logicUndervoltageFlag,
  input wire logic storageCorruptionFlag,
  input wire logic timeoutGuardFlag,
  input wire logic writeEnduranceFlag,
  input wire logic startupBrakeRequest,
  output logic excitationEnable,
  output logic lowSideAllOn,
  output logic allOutputsOff,
  output logic directionForward,
  output logic dcAlignStart,
  output logic rampUpStart,
  output logic gateDriverStandby,
  output logic restartRequest,
  output logic faultPinN,
  output logic [4:0] faultPinSourceSelect
);

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  logic [1:0] pinsSynced;
  logic dirPinS;
  logic resetPinS;

  pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk(clk),
    .rstn(rstn),
    .pinIn({directionPin, hardwareResetPinN}),
    .pinOut(pinsSynced)
  );

  assign dirPinS = pinsSynced[1];
  assign resetPinS = pinsSynced[0];

  // ----------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------
  logic addrPhase;
  logic wrPhase_reg;
  logic [11:0] wrAddr_reg;
  logic rdStart;
  logic [11:0] addrLow;

  assign addrPhase = hsel & hready & htrans[1];
  assign rdStart = addrPhase & ~hwrite;
  assign addrLow = haddr[11:0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPhase_reg <= 1'b0;
      wrAddr_reg <= 12'h000;
    end else if (hready) begin
      wrPhase_reg <= addrPhase & hwrite;
      wrAddr_reg <= addrLow;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------
  run_ctrl_t run_reg;
  run_ctrl_t run_next;
  logic [2:0] srcHi_reg;
  logic [2:0] srcHi_next;
  logic wrRun;
  logic wrSrcHi;

  assign wrRun = wrPhase_reg & (wrAddr_reg == `ADDR_RUN_CONTROL);
  assign wrSrcHi = wrPhase_reg & (wrAddr_reg == `ADDR_SOURCE_HI);

  assign run_next = wrRun ? run_ctrl_t'(hwdata[`SETTINGS_MSB:0])
      : run_reg;
  assign srcHi_next = wrSrcHi ? hwdata[`SRC_HI_MSB:`SRC_HI_LSB]
      : srcHi_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_reg <= run_ctrl_t'(`RUN_CONTROL_RESET);
      srcHi_reg <= `SOURCE_HI_RESET;
    end else begin
      run_reg <= run_next;
      srcHi_reg <= srcHi_next;
    end
  end

  assign faultPinSourceSelect = {srcHi_reg, run_reg.sourceLo};

  // ----------------------------------------------------------
  // Fault flags
  // ----------------------------------------------------------
  logic anyFault;
  logic generalFaultFlag;
  logic [5:0] flagField;

  assign anyFault = desyncFault | softOvercurrentProtection
      | hardOvercurrentProtection | logicUndervoltageFlag
      | storageCorruptionFlag | timeoutGuardFlag | writeEnduranceFlag;
  assign generalFaultFlag = anyFault;

  assign flagField = {generalFaultFlag, logicUndervoltageFlag,
      storageCorruptionFlag, timeoutGuardFlag, softOvercurrentProtection,
      writeEnduranceFlag};

  // ----------------------------------------------------------
  // Restart and coast control
  // ----------------------------------------------------------
  logic coastHold;
  logic restartPulse;

  fault_response u_fault_response (
    .clk(clk),
    .rstn(rstn),
    .run(run_reg.run),
    .brakeCommand(run_reg.brakeCommand),
    .autoRestartSelect(run_reg.autoRestartSelect),
    .faultDisplayLatch(run_reg.faultDisplayLatch),
    .desyncFault(desyncFault),
    .softOvercurrent(softOvercurrentProtection),
    .hardOvercurrent(hardOvercurrentProtection),
    .restartPulse(restartPulse),
    .coastHold(coastHold)
  );

  // ----------------------------------------------------------
  // Drive decisions
  // ----------------------------------------------------------
  logic faultShutdown;
  logic brakeNow;
  logic driveNow;

  assign faultShutdown = run_reg.faultActionSelect & anyFault;
  assign brakeNow = ~faultShutdown & ((run_reg.run & run_reg.brakeCommand)
      | startupBrakeRequest);
  assign driveNow = run_reg.run & ~coastHold & ~faultShutdown
      & ~brakeNow;

  logic excite_reg;
  logic lowSide_reg;
  logic allOff_reg;
  logic forward_reg;
  logic dcAlign_reg;
  logic standby_reg;
  logic restart_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      excite_reg <= 1'b0;
      lowSide_reg <= 1'b0;
      allOff_reg <= 1'b1;
      forward_reg <= 1'b1;
      dcAlign_reg <= 1'b0;
      standby_reg <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      excite_reg <= driveNow;
      lowSide_reg <= brakeNow;
      allOff_reg <= ~driveNow & ~brakeNow;
      forward_reg <= ~(run_reg.direction ^ dirPinS);
      dcAlign_reg <= run_reg.startupStyleSelect;
      standby_reg <= ~run_reg.gateDriverStandbySelect & ~resetPinS;
      restart_reg <= restartPulse;
    end
  end

  assign excitationEnable = excite_reg;
  assign lowSideAllOn = lowSide_reg;
  assign allOutputsOff = allOff_reg;
  assign directionForward = forward_reg;
  assign dcAlignStart = dcAlign_reg;
  assign rampUpStart = ~dcAlign_reg;
  assign gateDriverStandby = standby_reg;
  assign restartRequest = restart_reg;

  // ----------------------------------------------------------
  // Fault pin source and display latch
  // ----------------------------------------------------------
  logic [`SOURCE_COUNT-1:0] sourceVec;
  logic sourceNow;
  logic display_reg;
  logic display_next;

  always_comb begin
    sourceVec = '0;
    sourceVec[`SRC_GENERAL] = generalFaultFlag;
    sourceVec[`SRC_DESYNC] = desyncFault;
    sourceVec[`SRC_TIMEOUT] = timeoutGuardFlag;
    sourceVec[`SRC_HARD_OC] = hardOvercurrentProtection;
  end

  assign sourceNow = sourceVec[faultPinSourceSelect];
  assign display_next = run_reg.faultDisplayLatch
      ? (display_reg | sourceNow) : sourceNow;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      display_reg <= 1'b0;
    end else begin
      display_reg <= display_next;
    end
  end

  assign faultPinN = ~display_reg;

  // ----------------------------------------------------------
  // Read data
  // ----------------------------------------------------------
  logic [9:0] statusBits;
  logic [9:0] settingsSel;
  logic mapped;
  logic [31:0] rdValue;
  logic [31:0] rdData_reg;

  assign statusBits = {1'b0, display_reg, hardOvercurrentProtection,
      desyncFault, restart_reg, coastHold, allOff_reg, forward_reg,
      lowSide_reg, excite_reg};
  assign mapped = (addrLow == `ADDR_RUN_CONTROL)
      | (addrLow == `ADDR_SOURCE_HI) | (addrLow == `ADDR_STATUS);
  // Pending write is forwarded to a back-to-back read
  assign settingsSel = (addrLow == `ADDR_RUN_CONTROL) ? 10'(run_next)
      : (addrLow == `ADDR_SOURCE_HI) ? {5'h00, srcHi_next, 2'h0}
      : statusBits;
  assign rdValue = mapped ? {16'h0000, flagField, settingsSel}
      : 32'h00000000;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData_reg <= 32'h00000000;
    end else if (rdStart) begin
      rdData_reg <= rdValue;
    end
  end

  assign hrdata = rdData_reg;

endmodule // motor_run_control_register

// *** design/motor_run_defines.svh ***
// Offsets, field positions, reset values and counts of the run-control bank
`ifndef MOTOR_RUN_DEFINES_SVH
`define MOTOR_RUN_DEFINES_SVH

// Register byte addresses
`define ADDR_RUN_CONTROL 12'h000
`define ADDR_SOURCE_HI 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_DEC_MSB 11
`define ADDR_DEC_LSB 2

// Run-control field positions
`define RUN_BIT 0
`define DIR_BIT 1
`define BRAKE_BIT 2
`define RESTART_BIT 3
`define ACTION_BIT 4
`define STYLE_BIT 5
`define STANDBY_BIT 6
`define LATCH_BIT 7
`define SRC_LO_MSB 9
`define SRC_LO_LSB 8

// Source-select high bits in their own register
`define SRC_HI_MSB 4
`define SRC_HI_LSB 2

// Read layout: settings below, fault flags above
`define SETTINGS_MSB 9
`define FLAGS_MSB 15
`define FLAGS_LSB 10

// Reset values
`define RUN_CONTROL_RESET 10'h092
`define SOURCE_HI_RESET 3'h0

// Fault-pin source codes
`define SRC_GENERAL 5'h00
`define SRC_DESYNC 5'h01
`define SRC_TIMEOUT 5'h0F
`define SRC_HARD_OC 5'h13

// Lengths
`define SYNC_STAGES 2
`define SOURCE_COUNT 32

`endif

// *** design/motor_run_pkg.sv ***
// Types shared by the run-control bank
package motor_run_pkg;

  typedef enum logic [1:0] {
    TRANS_IDLE = 2'h0,
    TRANS_BUSY = 2'h1,
    TRANS_NONSEQ = 2'h2,
    TRANS_SEQ = 2'h3
  } htrans_t;

  typedef struct packed {
    logic [1:0] sourceLo;
    logic faultDisplayLatch;
    logic gateDriverStandbySelect;
    logic startupStyleSelect;
    logic faultActionSelect;
    logic autoRestartSelect;
    logic brakeCommand;
    logic direction;
    logic run;
  } run_ctrl_t;

endpackage

// *** design/pin_sync.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign pinOut = stage2_reg;

endmodule // pin_sync

// *** testbench/motor_host.sv ***
// Host controller model: bus master and pin drivers
`timescale 1ns/1ps
module motor_host (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic directionPin,
  output logic hardwareResetPinN,
  output logic hung
);
  logic dirReq = 1'h0;
  logic rstReq = 1'h1;
  assign directionPin = rstn & dirReq;
  assign hardwareResetPinN = rstn & rstReq;
  initial begin
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hung = 1'h0;
  end
  task automatic waitReady;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'h1 && n < 16) begin
      n++;
      @(posedge clk);
    end
    if (n == 16) hung <= 1'h1;
  endtask
  // Address phase, then data phase
  task automatic xfer(input logic w, input logic [31:0] a, d,
    output logic [31:0] q);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    waitReady;
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= d;
    waitReady;
    q = hrdata;
    hwdata <= ~d;
  endtask
  logic speedLevel = 1'h1;
  task automatic stopRun(output logic [31:0] q);
    speedLevel <= 1'h0;
    @(posedge clk);
    xfer(1'h1, 32'h0, 32'h0, q);
    speedLevel <= 1'h1;
  endtask
endmodule // motor_host

// *** testbench/motor_run_asserts.sv ***
// Port assertions of the run-control bank
`timescale 1ns/1ps
module motor_run_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hardwareResetPinN,
  input wire logic desyncFault,
  input wire logic softOvercurrentProtection,
  input wire logic hardOvercurrentProtection,
  input wire logic logicUndervoltageFlag,
  input wire logic storageCorruptionFlag,
  input wire logic timeoutGuardFlag,
  input wire logic writeEnduranceFlag,
  input wire logic startupBrakeRequest,
  input wire logic excitationEnable,
  input wire logic lowSideAllOn,
  input wire logic allOutputsOff,
  input wire logic dcAlignStart,
  input wire logic rampUpStart,
  input wire logic gateDriverStandby,
  input wire logic restartRequest
);
  wire logic rdTake = hsel & hreadyout & htrans[1] & ~hwrite;
  wire logic rsFault = desyncFault | softOvercurrentProtection
    | hardOvercurrentProtection;
  wire logic [5:0] flags = {rsFault | logicUndervoltageFlag
    | storageCorruptionFlag | timeoutGuardFlag | writeEnduranceFlag,
    logicUndervoltageFlag, storageCorruptionFlag, timeoutGuardFlag,
    softOvercurrentProtection, writeEnduranceFlag};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ----
  // Checks
  // ----
  brakeExcl_a: assert property
    (!(lowSideAllOn && excitationEnable)) else $error("brake with drive");
  offExcl_a: assert property
    (allOutputsOff |-> !excitationEnable && !lowSideAllOn)
    else $error("drive while off");
  styleInv_a: assert property
    (rampUpStart != dcAlignStart) else $error("start style clash");
  restartOne_a: assert property
    (restartRequest |=> !restartRequest) else $error("restart too long");
  restartCause_a: assert property
    (restartRequest |-> $past(rsFault, 2)) else $error("restart no cause");
  readFlags_a: assert property
    (rdTake ##1 $stable(flags) |-> hrdata[31:10] == {16'h0000, flags})
    else $error("read flags wrong");
  standbyPin_a: assert property
    (gateDriverStandby |-> !$past(hardwareResetPinN, 3))
    else $error("standby without pin");
  startBrake_a: assert property
    (startupBrakeRequest |=> lowSideAllOn || allOutputsOff)
    else $error("startup brake lost");
  cover property (restartRequest);
  cover property (lowSideAllOn);
  cover property (rdTake);
endmodule // motor_run_asserts
bind motor_run_control_register motor_run_asserts chk (.clk, .rstn,
  .hsel, .htrans, .hwrite, .hreadyout, .hrdata, .hardwareResetPinN,
  .desyncFault, .softOvercurrentProtection, .hardOvercurrentProtection,
  .logicUndervoltageFlag, .storageCorruptionFlag, .timeoutGuardFlag,
  .writeEnduranceFlag, .startupBrakeRequest, .excitationEnable,
  .lowSideAllOn, .allOutputsOff, .dcAlignStart, .rampUpStart,
  .gateDriverStandby, .restartRequest);

// *** testbench/tb.sv ***
// Testbench of the run-control bank
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
  logic clk, rstn, hsel, hwrite, hreadyout, hresp, hung, seen;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic directionPin, hardwareResetPinN, excitationEnable, lowSideAllOn;
  logic allOutputsOff, directionForward, dcAlignStart, rampUpStart;
  logic gateDriverStandby, restartRequest, faultPinN;
  logic [4:0] faultPinSourceSelect;
  logic [7:0] flt;
  int fails, checks;
  motor_run_control_register dut (.clk, .rstn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .directionPin, .hardwareResetPinN, .desyncFault(flt[0]),
    .softOvercurrentProtection(flt[1]),
    .hardOvercurrentProtection(flt[2]), .logicUndervoltageFlag(flt[3]),
    .storageCorruptionFlag(flt[4]), .timeoutGuardFlag(flt[5]),
    .writeEnduranceFlag(flt[6]), .startupBrakeRequest(flt[7]),
    .excitationEnable, .lowSideAllOn, .allOutputsOff, .directionForward,
    .dcAlignStart, .rampUpStart, .gateDriverStandby, .restartRequest,
    .faultPinN, .faultPinSourceSelect);
  motor_host host (.clk, .rstn, .hready(hreadyout), .hrdata, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .directionPin,
    .hardwareResetPinN, .hung);
  // ----
  // Helpers
  // ----
  task automatic wr(input logic [31:0] d);
    host.xfer(1'h1, 32'h0, d, q);
    repeat (3) @(posedge clk);
  endtask
  task automatic pulse(input logic [7:0] f);
    seen = 1'h0;
    flt <= f;
    @(posedge clk);
    flt <= 8'h0;
    repeat (5) begin
      @(posedge clk);
      seen |= restartRequest;
    end
  endtask
  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  // reset, layout, ignored bits
  task automatic t_regs;
    host.xfer(1'h0, 32'h0, 32'h0, q);
    `CHK(q, 32'h92)
    `CHK(hresp, 1'h0)
    host.xfer(1'h1, 32'h0, 32'hFFFF_FE81, q);
    host.xfer(1'h0, 32'h0, 32'h0, q);
    `CHK(q, 32'h281)
    host.xfer(1'h0, 32'hC, 32'h0, q);
    `CHK(q, 32'h0)
    repeat (2) @(posedge clk);
    `CHK(faultPinSourceSelect, 5'h02)
    `CHK(excitationEnable, 1'h1)
    host.xfer(1'h1, 32'h4, 32'hC, q);
    host.xfer(1'h0, 32'h4, 32'h0, q);
    `CHK(q, 32'hC)
    host.xfer(1'h0, 32'h8, 32'h0, q);
    `CHK(q, 32'h5)
    `CHK(faultPinSourceSelect, 5'h0E)
  endtask
  task automatic t_dir;
    for (int i = 0; i < 4; i++) begin
      host.dirReq <= i[1];
      wr({30'h0, i[0], 1'h1});
      `CHK(directionForward, i[0] == i[1])
    end
    host.dirReq <= 1'h0;
  endtask
  task automatic t_brake;
    wr(32'h5);
    `CHK({lowSideAllOn, excitationEnable}, 2'h2)
    wr(32'h4);
    `CHK({lowSideAllOn, excitationEnable}, 2'h0)
    flt <= 8'h80;
    repeat (2) @(posedge clk);
    `CHK(lowSideAllOn, 1'h1)
    flt <= 8'h0;
  endtask
  task automatic t_fault;
    wr(32'h11);
    flt <= 8'h10;
    repeat (2) @(posedge clk);
    `CHK({allOutputsOff, excitationEnable}, 2'h2)
    host.xfer(1'h0, 32'h0, 32'h0, q);
    `CHK(q[15:10], 6'h28)
    wr(32'h1);
    `CHK(excitationEnable, 1'h1)
    flt <= 8'h0;
    host.xfer(1'h0, 32'h0, 32'h0, q);
    `CHK(q, 32'h1)
  endtask
  task automatic t_restart;
    wr(32'h89);
    pulse(8'h04);
    `CHK(seen, 1'h1)
    wr(32'h09);
    pulse(8'h04);
    `CHK(seen, 1'h0)
    wr(32'h81);
    pulse(8'h01);
    `CHK({seen, excitationEnable}, 2'h0)
    host.stopRun(q);
  endtask
  task automatic t_style;
    host.rstReq <= 1'h0;
    wr(32'h20);
    `CHK({dcAlignStart, rampUpStart, gateDriverStandby}, 3'h5)
    wr(32'h40);
    `CHK({dcAlignStart, rampUpStart, gateDriverStandby}, 3'h2)
    host.rstReq <= 1'h1;
  endtask
  task automatic t_pin;
    wr(32'h380);
    `CHK(faultPinSourceSelect, 5'h0F)
    flt <= 8'h20;
    @(posedge clk);
    flt <= 8'h0;
    repeat (3) @(posedge clk);
    `CHK(faultPinN, 1'h0)
    wr(32'h0);
    `CHK(faultPinN, 1'h1)
  endtask
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  always @(posedge hung) begin
    fails++;
    stop_test;
  end
  initial begin
    rstn = 1'h0;
    flt = 8'h0;
    fails = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    t_regs;
    t_dir;
    t_brake;
    t_fault;
    t_restart;
    t_style;
    t_pin;
    stop_test;
  end
endmodule // tb
